// *** smc_pkg.sv ***
// Package: register map, field positions, reset values and timing of the serial channel.
package smc_pkg;
	localparam int ADR_W = 5;
	localparam logic [4:0] OFS_FORMAT = 5'h00;
	localparam logic [4:0] OFS_CONTROL = 5'h04;
	localparam logic [4:0] OFS_TX_HOLD = 5'h08;
	localparam logic [4:0] OFS_FLAGS = 5'h0c;
	localparam logic [4:0] OFS_RX_HOLD = 5'h10;
	localparam logic [4:0] OFS_BIT_RATE = 5'h14;
	localparam int FMT_SYNC = 7;
	localparam int FMT_CHR7 = 6;
	localparam int FMT_PAR = 5;
	localparam int FMT_ODD = 4;
	localparam int FMT_STOP2 = 3;
	localparam int FMT_MP = 2;
	localparam int FMT_CKS_HI = 1;
	localparam int FMT_CKS_LO = 0;
	localparam int CTL_TIE = 7;
	localparam int CTL_RIE = 6;
	localparam int CTL_TE = 5;
	localparam int CTL_RE = 4;
	localparam int CTL_MULTIPROC_IRQ_EN = 3;
	localparam int CTL_TX_END_IRQ_EN = 2;
	localparam int CTL_CLOCK_SRC_EXT = 1;
	localparam int CTL_CLOCK_OUT_EN = 0;
	localparam int FLG_TX_HOLDING_EMPTY = 7;
	localparam int FLG_RX_HOLDING_FULL = 6;
	localparam int FLG_OVERRUN_ERR_FLAG = 5;
	localparam int FLG_FER = 4;
	localparam int FLG_PER = 3;
	localparam int FLG_TEND = 2;
	localparam int FLG_MPB = 1;
	localparam int FLG_MPBT = 0;
	localparam logic [7:0] FLG_CLEARABLE = 8'hf8;
	localparam logic [7:0] FLG_ERRORS = 8'h38;
	localparam logic [7:0] FLG_RX = 8'h78;
	localparam logic [7:0] RST_FORMAT = 8'h00;
	localparam logic [7:0] RST_CONTROL = 8'h00;
	localparam logic [7:0] RST_TX_HOLD = 8'hff;
	localparam logic [7:0] RST_FLAGS = 8'h84;
	localparam logic [7:0] RST_RX_HOLD = 8'h00;
	localparam logic [7:0] RST_BIT_RATE = 8'hff;
	localparam logic [5:0] PRE_DIV1 = 6'h00;
	localparam logic [5:0] PRE_DIV4 = 6'h03;
	localparam logic [5:0] PRE_DIV16 = 6'h0f;
	localparam logic [5:0] PRE_DIV64 = 6'h3f;
	localparam logic [3:0] ASYNC_LAST = 4'hf;
	localparam logic [3:0] ASYNC_MID = 4'h7;
	localparam logic [3:0] LEN_BASE = 4'h8;
	localparam logic [3:0] LEN_SYNC = 4'h7;
	typedef enum logic [1:0] {TX_IDLE, TX_SEND} smc_tx_type;
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA} smc_rx_type;
endpackage

// *** smc_baud.sv ***
// Baud generator: clock prescaler and bit rate divider giving a one-cycle tick.
`timescale 1ns/10ps
module smc_baud (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [1:0] prescale_sel_i,
	input wire logic [7:0] bit_rate_i,
	output logic tick_o
);
	import smc_pkg::*;

	typedef struct packed {
		logic [5:0] pre;
		logic [7:0] cnt;
		logic tick;
	} smc_baud_type;

	smc_baud_type q;
	smc_baud_type n;
	logic [5:0] mask;

	// The prescaler runs free, so a mask compare gives all four rates from one counter.
	always_comb
	begin
		case (prescale_sel_i)
			2'h0: mask = PRE_DIV1;
			2'h1: mask = PRE_DIV4;
			2'h2: mask = PRE_DIV16;
			default: mask = PRE_DIV64;
		endcase
		n = q;
		n.tick = 1'b0;
		n.pre = q.pre + 6'h01;
		if ((q.pre & mask) == mask) // R10
		begin
			if (q.cnt == bit_rate_i)
			begin
				n.cnt = 8'h00;
				n.tick = 1'b1;
			end
			else
				n.cnt = q.cnt + 8'h01;
		end
		if (rst_i)
			n = '0;
	end

	always_ff @(posedge clk_i)
	begin
		q <= n;
	end

	assign tick_o = q.tick;
endmodule // smc_baud

// *** smc_serial.sv ***
// Serial channel: format and control registers, Wishbone slave, transmitter and receiver.
//
// Added by the designer: register access over Wishbone and the register addresses.
`timescale 1ns/10ps
// Function
// R01: Format bit 7 picks async or sync mode.
// R02: Bit 6 picks seven data bits, async only.
// R03: Seven-bit characters drop holding bit 7.
// R04: Parity added and checked only in async.
// R05: Bit 4 picks even or odd parity.
// R06: Parity sense ignored without async parity.
// R07: One or two stop bits; none in sync.
// R08: Receiver checks only the first stop bit.
// R09: Multiprocessor format overrides parity, async only.
// R10: Prescaler divides by 1, 4, 16, 64.
// R11: Both registers reset to zero.
// R12: Empty flag with enable raises transmit request.
// R13: Read-then-clear or disable withdraws transmit request.
// R14: Full flag or errors raise receive requests.
// R15: Read-then-clear or disable withdraws receive requests.
// R16: Transmitter off holds empty flag at one.
// R17: Transmission starts once empty flag is cleared.
// R18: Software sets format before enabling transmitter.
// R19: Control bit 4 enables the receiver.
// R20: Receiver off keeps flags; start on start bit.
// R21: External async clock 16x; output at bit rate.
module smc_serial (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [smc_pkg::ADR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic rxd_i,
	output logic txd_o,
	input wire logic sck_i,
	output logic sck_o,
	output logic sck_oe_n_o,
	output logic tx_empty_irq_o,
	output logic rx_full_irq_o,
	output logic rx_error_irq_o
);
	import smc_pkg::*;

	typedef struct packed {
		logic [7:0] fmt, ctl, txh, rxh, brr, flg, seen, rdat;
		logic ack;
		logic [2:0] sck_s;
		logic [1:0] rxd_s;
		logic [3:0] bph;
		smc_tx_type tx_st;
		logic [11:0] tx_sh;
		logic [3:0] tx_cnt;
		logic txd;
		smc_rx_type rx_st;
		logic [9:0] rx_sh;
		logic [3:0] rx_ph, rx_cnt;
		logic sck, sck_oe_n, irq_tx, irq_rx, irq_er;
	} smc_state_type;

	smc_state_type q;
	smc_state_type n;
	logic sync, chr7, mp_eff, pe_eff, stop2, ext, rxd, ext_rise, ext_fall;
	logic baud_tick, tick, run, rise, fall, bedge, acc, wr, rd;
	logic tx_load, tx_par, tx_extra;
	logic [3:0] rx_last;
	logic [7:0] tdat;
	logic [11:0] frame;

	smc_baud u_baud (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.prescale_sel_i(q.fmt[FMT_CKS_HI:FMT_CKS_LO]),
		.bit_rate_i(q.brr),
		.tick_o(baud_tick)
	);

	assign sync = q.fmt[FMT_SYNC]; // R01
	assign chr7 = q.fmt[FMT_CHR7] & !sync; // R02
	assign mp_eff = q.fmt[FMT_MP] & !sync; // R09
	assign pe_eff = q.fmt[FMT_PAR] & !sync & !mp_eff; // R04 R06 R09
	assign stop2 = q.fmt[FMT_STOP2] & !sync; // R07
	assign ext = q.ctl[CTL_CLOCK_SRC_EXT];
	assign rxd = q.rxd_s[1];
	assign ext_rise = q.sck_s[1] & !q.sck_s[2];
	assign ext_fall = !q.sck_s[1] & q.sck_s[2];
	// An external async clock already runs at sixteen ticks per bit.
	assign tick = ext ? ext_rise : baud_tick; // R21
	// The internal sync clock only runs while there is work, so an idle link shows a high clock.
	assign run = q.tx_st == TX_SEND || (q.ctl[CTL_TE] && !q.flg[FLG_TX_HOLDING_EMPTY]) || (q.ctl[CTL_RE] && !q.flg[FLG_RX_HOLDING_FULL]);
	assign rise = sync && (ext ? ext_rise : baud_tick && !q.bph[0]);
	assign fall = sync && (ext ? ext_fall : baud_tick && q.bph[0] && run);
	assign bedge = sync ? fall : tick && q.bph == ASYNC_LAST;
	assign acc = wb_cyc_i && wb_stb_i && !q.ack;
	assign wr = acc && wb_we_i && wb_sel_i[0];
	assign rd = acc && !wb_we_i;

	assign tdat = chr7 ? {1'b0, q.txh[6:0]} : q.txh; // R03
	assign tx_par = ^tdat ^ q.fmt[FMT_ODD]; // R05
	assign tx_extra = mp_eff ? q.flg[FLG_MPBT] : (pe_eff ? tx_par : 1'b1);
	assign frame = sync ? {4'hf, q.txh} : (chr7 ? {3'h7, tx_extra, q.txh[6:0], 1'b0} : {2'h3, tx_extra, q.txh, 1'b0});
	assign rx_last = sync ? LEN_SYNC : LEN_BASE - {3'h0, chr7} + {3'h0, pe_eff | mp_eff};
	assign tx_load = bedge && (q.tx_st == TX_IDLE || q.tx_cnt == 4'h0) && q.ctl[CTL_TE] && !q.flg[FLG_TX_HOLDING_EMPTY]; // R17

	always_comb
	begin
		logic [7:0] wd;
		logic [3:0] tx_len;
		logic [7:0] rdat;
		logic xbit;
		wd = wb_dat_i[7:0];
		// The async frame also carries its start bit, so one more shift than the receiver counts.
		tx_len = sync ? LEN_SYNC : rx_last + {3'h0, stop2} + 4'h1;
		rdat = 8'h00;
		xbit = 1'b0;
		n = q;
		n.sck_s = {q.sck_s[1:0], sck_i};
		n.rxd_s = {q.rxd_s[0], rxd_i};
		n.ack = acc;

		// Register access; clears come first so that hardware sets below win.
		if (acc)
		begin
			n.rdat = 8'h00;
			case (wb_adr_i)
				OFS_FORMAT:
				begin
					n.rdat = q.fmt;
					if (wr)
						n.fmt = wd; // R11
				end
				OFS_CONTROL:
				begin
					n.rdat = q.ctl;
					if (wr)
						n.ctl = wd; // R11 R19
				end
				OFS_TX_HOLD:
				begin
					n.rdat = q.txh;
					if (wr)
						n.txh = wd;
				end
				OFS_FLAGS:
				begin
					n.rdat = q.flg;
					if (rd)
						n.seen = q.seen | q.flg;
					if (wr)
					begin
						for (int i = 0; i < 8; i++)
						begin
							if (FLG_CLEARABLE[i] && !wd[i] && q.seen[i])
								n.flg[i] = 1'b0; // R13 R15
						end
						if (!wd[FLG_TX_HOLDING_EMPTY] && q.seen[FLG_TX_HOLDING_EMPTY])
							n.flg[FLG_TEND] = 1'b0;
						n.flg[FLG_MPBT] = wd[FLG_MPBT];
					end
				end
				OFS_RX_HOLD:
					n.rdat = q.rxh;
				OFS_BIT_RATE:
				begin
					n.rdat = q.brr;
					if (wr)
						n.brr = wd;
				end
				default:
					n.rdat = 8'h00;
			endcase
		end

		// Bit phase: sixteen ticks per async bit, one clock half per tick with the internal sync clock.
		if (sync)
		begin
			if (!ext && (rise || fall))
				n.bph[0] = !q.bph[0];
		end
		else if (tick)
			n.bph = q.bph + 4'h1;
		n.sck = 1'b1;
		n.sck_oe_n = 1'b1;
		if (!ext && (sync || q.ctl[CTL_CLOCK_OUT_EN]))
		begin
			n.sck_oe_n = 1'b0;
			n.sck = sync ? n.bph[0] : n.bph[3]; // R21
		end

		// Transmitter: a new character is taken only on a bit boundary.
		if (tx_load)
		begin
			n.tx_st = TX_SEND;
			n.tx_sh = frame; // R02 R03 R04 R07
			n.txd = frame[0];
			n.tx_cnt = tx_len;
			n.flg[FLG_TX_HOLDING_EMPTY] = 1'b1; // R12
			n.flg[FLG_TEND] = 1'b0;
		end
		else
		begin
			case (q.tx_st)
				TX_IDLE:
					n.txd = 1'b1;
				TX_SEND:
				begin
					if (bedge)
					begin
						if (q.tx_cnt != 4'h0)
						begin
							n.tx_sh = {1'b1, q.tx_sh[11:1]};
							n.txd = q.tx_sh[1];
							n.tx_cnt = q.tx_cnt - 4'h1;
						end
						else
						begin
							n.tx_st = TX_IDLE;
							n.txd = 1'b1;
							n.flg[FLG_TEND] = 1'b1;
						end
					end
				end
				default:
					n.tx_st = TX_IDLE;
			endcase
		end

		// Receiver: turning it off abandons the character but leaves every flag alone.
		if (!q.ctl[CTL_RE])
			n.rx_st = RX_IDLE; // R19 R20
		else
		begin
			case (q.rx_st)
				RX_IDLE:
				begin
					n.rx_cnt = 4'h0;
					n.rx_ph = 4'h0;
					if (sync)
						n.rx_st = RX_DATA; // R20
					else if (tick && !rxd)
						n.rx_st = RX_START; // R20
				end
				RX_START:
				begin
					if (tick)
					begin
						n.rx_ph = q.rx_ph + 4'h1;
						if (q.rx_ph == ASYNC_MID)
						begin
							n.rx_ph = 4'h0;
							n.rx_st = rxd ? RX_IDLE : RX_DATA;
						end
					end
				end
				RX_DATA:
				begin
					if (tick && !sync)
						n.rx_ph = q.rx_ph + 4'h1;
					if (sync ? rise : tick && q.rx_ph == ASYNC_LAST)
					begin
						n.rx_sh[q.rx_cnt] = rxd;
						n.rx_cnt = q.rx_cnt + 4'h1;
						if (q.rx_cnt == rx_last)
						begin
							n.rx_st = RX_IDLE;
							rdat = chr7 ? {1'b0, n.rx_sh[6:0]} : n.rx_sh[7:0];
							xbit = chr7 ? n.rx_sh[7] : n.rx_sh[8];
							// A full holding register keeps its old byte; the new one is lost.
							if (q.flg[FLG_RX_HOLDING_FULL])
								n.flg[FLG_OVERRUN_ERR_FLAG] = 1'b1;
							else
							begin
								n.rxh = rdat;
								n.flg[FLG_RX_HOLDING_FULL] = 1'b1; // R14
								if (!sync && !rxd)
									n.flg[FLG_FER] = 1'b1; // R08
								if (pe_eff && (^rdat ^ xbit ^ q.fmt[FMT_ODD]))
									n.flg[FLG_PER] = 1'b1; // R04 R05
								if (mp_eff)
									n.flg[FLG_MPB] = xbit; // R09
							end
						end
					end
				end
				default:
					n.rx_st = RX_IDLE;
			endcase
		end

		if (!n.ctl[CTL_TE])
			n.flg[FLG_TX_HOLDING_EMPTY] = 1'b1; // R16
		n.seen = n.seen & n.flg;
		n.irq_tx = n.ctl[CTL_TIE] && n.flg[FLG_TX_HOLDING_EMPTY]; // R12 R13
		n.irq_rx = n.ctl[CTL_RIE] && n.flg[FLG_RX_HOLDING_FULL]; // R14 R15
		n.irq_er = n.ctl[CTL_RIE] && |(n.flg & FLG_ERRORS); // R14 R15

		if (rst_i)
		begin
			n = '0;
			n.fmt = RST_FORMAT; // R11
			n.ctl = RST_CONTROL; // R11
			n.txh = RST_TX_HOLD;
			n.flg = RST_FLAGS;
			n.rxh = RST_RX_HOLD;
			n.brr = RST_BIT_RATE;
			n.tx_st = TX_IDLE;
			n.rx_st = RX_IDLE;
			n.txd = 1'b1;
			n.sck = 1'b1;
			n.sck_oe_n = 1'b1;
		end
	end

	always_ff @(posedge clk_i)
	begin
		q <= n;
	end

	assign wb_dat_o = {24'h000000, q.rdat};
	assign wb_ack_o = q.ack;
	assign txd_o = q.txd;
	assign sck_o = q.sck;
	assign sck_oe_n_o = q.sck_oe_n;
	assign tx_empty_irq_o = q.irq_tx;
	assign rx_full_irq_o = q.irq_rx;
	assign rx_error_irq_o = q.irq_er;

	chk_reset_clears_regs: assert property (@(posedge clk_i) disable iff (rst_i) // R11
		$past(rst_i) |-> q.fmt == RST_FORMAT && q.ctl == RST_CONTROL && q.flg == RST_FLAGS)
		else $error("registers not at reset values after reset");
	chk_empty_locked: assert property (@(posedge clk_i) disable iff (rst_i) // R16
		!q.ctl[CTL_TE] |-> q.flg[FLG_TX_HOLDING_EMPTY] && !tx_load)
		else $error("empty flag not held while transmitter is off");
	chk_tx_request: assert property (@(posedge clk_i) disable iff (rst_i) // R12
		tx_empty_irq_o == (q.ctl[CTL_TIE] && q.flg[FLG_TX_HOLDING_EMPTY]))
		else $error("transmit request disagrees with enable and empty flag");
	chk_rx_error_req: assert property (@(posedge clk_i) disable iff (rst_i) // R14
		rx_error_irq_o == (q.ctl[CTL_RIE] && (q.flg & FLG_ERRORS) != 8'h00))
		else $error("error request disagrees with enable and error flags");
	chk_start_bit_low: assert property (@(posedge clk_i) disable iff (rst_i) // R17
		tx_load && !sync |=> !txd_o && q.tx_st == TX_SEND && q.flg[FLG_TX_HOLDING_EMPTY])
		else $error("async transmission did not open with a start bit");
	chk_seven_bit_drop: assert property (@(posedge clk_i) disable iff (rst_i) // R03
		tx_load && chr7 && !pe_eff && !mp_eff && !stop2 |=> q.tx_cnt == 4'h8 && q.tx_sh[8])
		else $error("seven bit frame length or stop bit wrong");
	chk_two_stop_bits: assert property (@(posedge clk_i) disable iff (rst_i) // R07
		tx_load && !sync && !chr7 && !pe_eff && !mp_eff && stop2 |=> q.tx_cnt == 4'ha && &q.tx_sh[10:9])
		else $error("two stop bit frame wrong");
	chk_sync_frame: assert property (@(posedge clk_i) disable iff (rst_i) // R02
		tx_load && sync |=> q.tx_cnt == 4'h7 && q.tx_sh[11:8] == 4'hf)
		else $error("sync frame is not eight bare data bits");
	chk_parity_sense: assert property (@(posedge clk_i) disable iff (rst_i) // R05
		tx_load && pe_eff && !chr7 |=> (^q.tx_sh[9:1]) == $past(q.fmt[FMT_ODD]))
		else $error("transmitted parity has the wrong sense");
	chk_rx_off_flags: assert property (@(posedge clk_i) disable iff (rst_i) // R20
		!q.ctl[CTL_RE] && !acc |=> (q.flg & FLG_RX) == ($past(q.flg) & FLG_RX))
		else $error("receive flags changed while receiver is off");
endmodule // smc_serial

// *** smc_peer.sv ***
// Remote serial peer: drives the receive line and captures transmitted frames.
`timescale 1ns/10ps
module smc_peer (
	input wire logic clk_i,
	input wire logic txd_i,
	output logic rxd_o
);
	initial rxd_o = 1'b1;

	// Sends n bits from bit 0 upward, each held bt clocks; the line is left idle high.
	task automatic send(input logic [15:0] bits, input int n, input int bt);
		for (int i = 0; i < n; i++)
		begin
			rxd_o <= bits[i];
			repeat (bt) @(posedge clk_i);
		end
		rxd_o <= 1'b1;
	endtask

	// Samples mid-bit so that small edge offsets of the sender do not matter.
	task automatic grab(output logic [15:0] bits, input int n, input int bt);
		int w;
		bits = 16'hffff;
		w = 0;
		while (txd_i !== 1'b0 && w < 4000)
		begin
			@(posedge clk_i);
			w++;
		end
		repeat (bt / 2) @(posedge clk_i);
		for (int i = 0; i < n; i++)
		begin
			bits[i] = txd_i;
			repeat (bt) @(posedge clk_i);
		end
	endtask
endmodule // smc_peer

// *** testbench.sv ***
// Self-checking testbench of the serial channel registers and frames.
`timescale 1ns/10ps
module testbench;
	import smc_pkg::*;
	logic clk_i, rst_i, cyc, stb, we, txd, rxd, sck_o, sck_oe_n, tx_irq, rx_irq, er_irq, ack;
	logic [4:0] adr;
	logic [3:0] sel;
	logic [31:0] dat, dat_o;
	logic [15:0] b, g;
	logic [7:0] d, q, r;
	logic m;
	int error_cnt, checks, n, bt;
	logic sck;
	time t;
	logic [7:0] fmts [6] = '{8'h08, 8'h50, 8'h60, 8'h38, 8'h34, 8'h01};

	smc_serial DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
		.rxd_i(rxd), .txd_o(txd), .sck_i(sck), .sck_o(sck_o), .sck_oe_n_o(sck_oe_n),
		.tx_empty_irq_o(tx_irq), .rx_full_irq_o(rx_irq), .rx_error_irq_o(er_irq));
	smc_peer PEER (.clk_i(clk_i), .txd_i(txd), .rxd_o(rxd));

	always #20 clk_i = ~clk_i;

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] v);
		checks++;
		if (v !== e)
		begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", nm, e, v);
		end
	endtask

	task automatic wb(input logic w, input logic [4:0] a, input logic [7:0] x, output logic [7:0] y);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= 4'hf;
		dat <= {24'h0, x};
		@(posedge clk_i);
		// Only the watchdog ends a wait for the acknowledge.
		while (ack !== 1'b1)
			@(posedge clk_i);
		y = dat_o[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge clk_i);
	endtask

	task automatic wr(input logic [4:0] a, input logic [7:0] x);
		logic [7:0] y;
		wb(1'b1, a, x, y);
	endtask

	task automatic rd(input logic [4:0] a, input logic [7:0] e, input string nm);
		logic [7:0] y;
		wb(1'b0, a, 8'h00, y);
		chk(nm, 16'(e), 16'(y));
	endtask

	// Interrupt levels are sampled at the falling edge, where they have settled.
	task automatic irq(input logic [2:0] e);
		@(negedge clk_i);
		chk("irq", 16'(e), 16'({tx_irq, rx_irq, er_irq}));
		@(posedge clk_i);
	endtask

	// Frame model: start, 7 or 8 data bits, multiprocessor or parity bit, one or two stops.
	function automatic int frame(input logic [7:0] f, input logic [7:0] x, input logic mb, output logic [15:0] o);
		int k;
		logic p;
		o = 16'hffff;
		o[0] = 1'b0;
		k = 1;
		p = f[FMT_ODD];
		for (int i = 0; i < (f[FMT_CHR7] ? 7 : 8); i++)
		begin
			o[k] = x[i];
			p = p ^ x[i];
			k++;
		end
		if (f[FMT_MP] || f[FMT_PAR])
		begin
			o[k] = f[FMT_MP] ? mb : p;
			k++;
		end
		return k + (f[FMT_STOP2] ? 2 : 1);
	endfunction

	task automatic final_report();
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	initial
	begin
		repeat (90000) @(posedge clk_i);
		error_cnt++;
		final_report();
	end

	initial
	begin
		clk_i = 1'b0;
		rst_i = 1'b1;
		{cyc, stb, we} = 3'b000;
		adr = 5'h00;
		sel = 4'hf;
		dat = 32'h0;
		sck = 1'b0;
		error_cnt = 0;
		checks = 0;
		void'($urandom(32'h7e22833e));
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rd(OFS_FORMAT, 8'h00, "format");
		rd(OFS_CONTROL, 8'h00, "control");
		rd(5'h18, 8'h00, "unmapped");
		r = 8'($urandom);
		wr(OFS_FORMAT, r);
		rd(OFS_FORMAT, r, "format rw");
		wr(OFS_CONTROL, r);
		rd(OFS_CONTROL, r, "control rw");
		wr(OFS_CONTROL, 8'h00);
		wr(OFS_BIT_RATE, 8'h00);
		wr(OFS_TX_HOLD, 8'h55);
		wb(1'b0, OFS_FLAGS, 8'h00, q);
		wr(OFS_FLAGS, 8'h00);
		wb(1'b0, OFS_FLAGS, 8'h00, q);
		chk("empty held", 16'(q[FLG_TX_HOLDING_EMPTY]), 16'h1);
		$display("test registers done");
		foreach (fmts[k])
		begin
			d = 8'($urandom) | 8'h80;
			m = 1'($urandom);
			n = frame(fmts[k], d, m, b);
			bt = 16 << (2 * fmts[k][1:0]);
			wr(OFS_FORMAT, fmts[k]);
			wr(OFS_TX_HOLD, d);
			wr(OFS_CONTROL, 8'ha0);
			wb(1'b0, OFS_FLAGS, 8'h00, q);
			irq(3'b100);
			wr(OFS_FLAGS, {7'h00, m});
			PEER.grab(g, n, bt);
			chk("tx frame", b, g);
			irq(3'b100);
			wr(OFS_CONTROL, 8'h00);
			irq(3'b000);
		end
		wr(OFS_FORMAT, 8'h80);
		d = 8'($urandom) & 8'hfe;
		wr(OFS_TX_HOLD, d);
		wr(OFS_CONTROL, 8'h20);
		wb(1'b0, OFS_FLAGS, 8'h00, q);
		wr(OFS_FLAGS, 8'h00);
		PEER.grab(g, 8, 2);
		chk("sync frame", {8'hff, d}, g);
		wr(OFS_CONTROL, 8'h00);
		$display("test transmit done");
		wr(OFS_FORMAT, 8'h20);
		wr(OFS_CONTROL, 8'h50);
		for (int j = 0; j < 2; j++)
		begin
			d = 8'($urandom);
			n = frame(8'h20, d, 1'b0, b);
			b[9] = b[9] ^ j[0];
			PEER.send(b, n, 16);
			repeat (40) @(posedge clk_i);
			wb(1'b0, OFS_FLAGS, 8'h00, q);
			chk("rx flags", 16'(j ? 8'h48 : 8'h40), 16'(q & FLG_RX));
			rd(OFS_RX_HOLD, d, "rx data");
			irq({1'b0, 1'b1, j[0]});
			if (j == 0)
			begin
				wr(OFS_FLAGS, 8'h00);
				irq(3'b000);
			end
		end
		wr(OFS_CONTROL, 8'h40);
		PEER.send(16'h0000, 11, 16);
		repeat (40) @(posedge clk_i);
		wb(1'b0, OFS_FLAGS, 8'h00, q);
		chk("rx off flags", 16'h48, 16'(q & FLG_RX));
		rd(OFS_RX_HOLD, d, "rx off data");
		irq(3'b011);
		wr(OFS_CONTROL, 8'h00);
		irq(3'b000);
		wr(OFS_FLAGS, 8'h00);
		wr(OFS_CONTROL, 8'h01);
		chk("clock pin driven", 16'h0, 16'(sck_oe_n));
		@(posedge sck_o);
		t = $time;
		@(posedge sck_o);
		chk("clock out period", 16'h280, 16'($time - t));
		@(posedge clk_i);
		wr(OFS_CONTROL, 8'h12);
		chk("clock pin released", 16'h1, 16'(sck_oe_n));
		d = 8'($urandom);
		n = frame(8'h20, d, 1'b0, b);
		fork
			PEER.send(b, n, 64);
			repeat (400)
			begin
				sck <= ~sck;
				repeat (2) @(posedge clk_i);
			end
		join
		repeat (40) @(posedge clk_i);
		rd(OFS_RX_HOLD, d, "ext clock data");
		wb(1'b0, OFS_FLAGS, 8'h00, q);
		chk("ext clock flags", 16'h40, 16'(q & FLG_RX));
		$display("test receive done");
		final_report();
	end
endmodule // testbench
